/* logic/spi_block.sv */
// Byte-wide serial peripheral, master or slave, with optional buffering
//
// Behaviour
// - bit_order 0 MSB first, 1 LSB first
// - Low select in master drops master, sets flag
// - Divider gives clock /4, /16, /64, /128
// - clock_double doubles master serial clock
// - No serial activity while disabled
// - buffered_mode adds buffers and separate flags
// - Wait-bit 0: first byte is dummy
// - Wait-bit 1: idle write loads shifter directly
// - select_line_ignore keeps master despite low select
// - Mode field picks sample and setup edges
// - Clock idles at leading edge's opposite level
// - Buffered enables gate flags; otherwise read zero
// - Legacy enable gates transfer-done flag
// - Receive flag tracks unread data, clearable
// - Transfer-done set per byte and fallback
// - Done flag cleared by vector or sequence
// - Transfer-complete set when all sent
// - Collision flag on write during transfer
// - Empty flag reflects transmit buffer state
// - Select-trigger flag on forced fallback
// - Overflow on third byte with buffers full
// - Write starts send; read pops buffer
// - Empty, receive, complete flags rise staggered
// - Slave select high aborts byte
`timescale 1ns/10ps
`include "spi_map.svh"

module spi_block
  import spi_pkg::*;
(
  input  wire logic       core_clk,     // Peripheral clock
  input  wire logic       rst,          // Async reset, active high
  input  wire logic [2:0] reg_addr,     // Register offset
  input  wire logic [7:0] reg_wdata,    // Write data
  input  wire logic       reg_write,    // Write strobe
  input  wire logic       reg_read,     // Read strobe
  output logic      [7:0] reg_rdata,    // Read data, cycle after strobe
  input  wire logic       vector_taken, // Interrupt vector taken
  output logic            irq,          // Interrupt request
  input  wire pins_in_t   pins_in,      // Serial pin inputs
  output pins_out_t       pins_out      // Serial pin outputs and enables
);

  function automatic logic [6:0] half_period(input logic [1:0] code,
                                             input logic dbl);
    logic [7:0] div;
    div = 8'h00;
    case (code)
      2'h0:    div = `DIV_CODE4;
      2'h1:    div = `DIV_CODE16;
      2'h2:    div = `DIV_CODE64;
      default: div = `DIV_CODE128;
    endcase
    // Half period of serial clock, doubled speed halves it
    half_period = dbl ? {1'b0, div[7:2]} : div[7:1];
  endfunction : half_period

  function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                          input logic b,
                                          input logic lsb_first);
    shift_in = lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction : shift_in

  function automatic logic first_bit(input logic [7:0] sh,
                                     input logic lsb_first);
    first_bit = lsb_first ? sh[0] : sh[7];
  endfunction : first_bit

  logic [7:0]    control_a;
  logic [7:0]    control_b;
  logic [7:0]    interrupt_enables;
  engine_state_t state;
  logic [7:0]    shreg;
  logic [7:0]    rx_hold;
  logic [7:0]    txbuf;
  logic          txbuf_full;
  logic          pending;
  logic [4:0]    edge_cnt;
  logic [6:0]    half_cnt;
  logic [2:0]    bit_cnt;
  logic          slave_mid;
  logic          sck_prev;
  logic          done;
  logic          done_d1;
  logic          done_d2;
  logic [7:0]    rx_first;
  logic [7:0]    rx_second;
  logic          rx_first_full;
  logic          rx_second_full;
  logic          xfer_flag;
  logic          collision_flag;
  logic          receive_complete_flag;
  logic          transfer_complete_flag;
  logic          select_trigger_flag;
  logic          receive_overflow_flag;
  logic          clear_armed_xfer;
  logic          clear_armed_col;

  logic enable;
  logic master;
  logic bit_order;
  logic buffered_mode;
  logic cpol;
  logic cpha;
  logic wr_data;
  logic rd_data;
  logic busy;
  logic fallback;
  logic direct_load;
  logic txbuf_write;
  logic slave_sel;
  logic lead_edge;
  logic trail_edge;
  logic slave_sample;
  logic slave_setup;
  logic buffer_empty_flag;

  assign enable        = control_a[`A_ENABLE];
  assign master        = control_a[`A_MASTER];
  assign bit_order     = control_a[`A_BIT_ORDER];
  assign buffered_mode = control_b[`B_BUFFERED];
  assign cpol          = control_b[`B_MODE_HI];
  assign cpha          = control_b[`B_MODE_LO];
  assign wr_data       = reg_write && reg_addr == `OFS_TX_RX_BYTE;
  assign rd_data       = reg_read && reg_addr == `OFS_TX_RX_BYTE;
  assign slave_sel     = enable && !master && !pins_in.ss_n;
  assign busy          = state == ST_MASTER ||
                         (state == ST_SLAVE && (bit_cnt != 3'd0 || slave_mid));
  // low select forces slave unless ignored
  assign fallback      = enable && master && !pins_in.ss_n &&
                         !control_b[`B_SELECT_IGNORE];
  // idle write with select high bypasses the buffer when the wait bit is set
  assign direct_load   = wr_data && !busy &&
                         (!buffered_mode ||
                          (control_b[`B_WAIT_RECEIVE] && enable &&
                           pins_in.ss_n && !pending));
  // otherwise buffered writes wait in the transmit buffer
  assign txbuf_write   = wr_data && buffered_mode && !direct_load &&
                         !txbuf_full;
  // empty flag only meaningful in buffered mode
  assign buffer_empty_flag = buffered_mode && !txbuf_full;
  // leading edge leaves the idle level
  assign lead_edge     = pins_in.sck != sck_prev && pins_in.sck != cpol;
  assign trail_edge    = pins_in.sck != sck_prev && pins_in.sck == cpol;
  assign slave_sample  = cpha ? trail_edge : lead_edge;
  assign slave_setup   = cpha ? lead_edge : trail_edge;

  // Configuration registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      control_a         <= `RST_REG;
      control_b         <= `RST_REG;
      interrupt_enables <= `RST_REG;
    end else begin
      if (reg_write && reg_addr == `OFS_CONTROL_A)
        control_a <= reg_wdata & 8'h77;
      else if (fallback)
        // hardware drops master; software must set it again
        control_a[`A_MASTER] <= 1'b0;
      if (reg_write && reg_addr == `OFS_CONTROL_B)
        control_b <= reg_wdata & 8'hc7;
      if (reg_write && reg_addr == `OFS_INTERRUPT_ENABLES)
        interrupt_enables <= reg_wdata & 8'hf1;
    end
  end

  // Transfer engine and pins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      shreg     <= 8'h00;
      rx_hold   <= 8'h00;
      pending   <= 1'b0;
      edge_cnt  <= 5'd0;
      half_cnt  <= 7'd0;
      bit_cnt   <= 3'd0;
      slave_mid <= 1'b0;
      sck_prev  <= 1'b0;
      done      <= 1'b0;
      pins_out  <= '0;
    end else begin
      done     <= 1'b0;
      sck_prev <= pins_in.sck;
      pins_out.sck_oe  <= enable && master;
      pins_out.mosi_oe <= enable && master;
      pins_out.miso_oe <= slave_sel;
      // data write or buffer move starts the next byte
      if (direct_load) begin
        shreg   <= reg_wdata;
        pending <= 1'b1;
      end else if (done && buffered_mode && txbuf_full) begin
        shreg   <= txbuf;
        pending <= 1'b1;
      end
      if (!enable || fallback) begin
        state        <= ST_IDLE;
        pins_out.sck <= cpol;
      end else begin
        case (state)
          ST_IDLE: begin
            // clock rests at the mode's idle level
            pins_out.sck <= cpol;
            bit_cnt      <= 3'd0;
            slave_mid    <= 1'b0;
            if (!master) begin
              state <= ST_SLAVE;
            // Buffer move needs a clock so the first bit is the new byte's
            end else if (pending || (buffered_mode && txbuf_full && !done)) begin
              state         <= ST_MASTER;
              edge_cnt      <= 5'd0;
              // divider applies in master mode only
              // doubled rate shortens the half period
              half_cnt      <= half_period(control_a[`A_DIV_HI:`A_DIV_LO],
                                           control_a[`A_CLOCK_DOUBLE]) - 7'd1;
              pins_out.mosi <= first_bit(shreg, bit_order);
              if (!direct_load)
                pending <= 1'b0;
            end
          end
          ST_MASTER: begin
            if (half_cnt != 7'd0) begin
              half_cnt <= half_cnt - 7'd1;
            end else begin
              half_cnt <= half_period(control_a[`A_DIV_HI:`A_DIV_LO],
                                      control_a[`A_CLOCK_DOUBLE]) - 7'd1;
              edge_cnt     <= edge_cnt + 5'd1;
              pins_out.sck <= ~pins_out.sck;
              // even edges lead; phase bit picks sample edge
              if (edge_cnt[0] == cpha) begin
                shreg <= shift_in(shreg, pins_in.miso, bit_order);
              end else begin
                pins_out.mosi <= first_bit(shreg, bit_order);
              end
              if (edge_cnt == `EDGES_PER_BYTE - 5'd1) begin
                state   <= ST_IDLE;
                done    <= 1'b1;
                // Trailing-edge sampling takes its last bit on this edge
                rx_hold <= cpha ? shift_in(shreg, pins_in.miso, bit_order) :
                                  shreg;
              end
            end
          end
          ST_SLAVE: begin
            if (master) begin
              state <= ST_IDLE;
            end else if (pins_in.ss_n) begin
              bit_cnt   <= 3'd0;
              slave_mid <= 1'b0;
              pins_out.miso <= first_bit(shreg, bit_order);
            end else if (slave_sample) begin
              shreg     <= shift_in(shreg, pins_in.mosi, bit_order);
              slave_mid <= 1'b1;
              bit_cnt   <= bit_cnt + 3'd1;
              if (bit_cnt == 3'd7) begin
                done    <= 1'b1;
                rx_hold <= shift_in(shreg, pins_in.mosi, bit_order);
              end
            end else if (slave_setup) begin
              pins_out.miso <= first_bit(shreg, bit_order);
              slave_mid     <= 1'b0;
            end else if (bit_cnt == 3'd0 && !slave_mid) begin
              pins_out.miso <= first_bit(shreg, bit_order);
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Transmit buffer and receive buffers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txbuf          <= 8'h00;
      txbuf_full     <= 1'b0;
      rx_first       <= 8'h00;
      rx_second      <= 8'h00;
      rx_first_full  <= 1'b0;
      rx_second_full <= 1'b0;
      done_d1        <= 1'b0;
      done_d2        <= 1'b0;
    end else begin
      // empty, then receive, then complete, one clock apart
      done_d1 <= done;
      done_d2 <= done_d1;
      if (done && txbuf_full)
        txbuf_full <= 1'b0;
      else if (txbuf_write) begin
        txbuf      <= reg_wdata;
        txbuf_full <= 1'b1;
      end
      if (!buffered_mode) begin
        txbuf_full     <= 1'b0;
        rx_first_full  <= 1'b0;
        rx_second_full <= 1'b0;
      end else begin
        // a read pops the second buffer, first moves down
        if (rd_data) begin
          rx_second      <= rx_first;
          rx_second_full <= rx_first_full;
          rx_first_full  <= 1'b0;
        end
        if (done_d1) begin
          if (!rx_second_full || (rd_data && !rx_first_full)) begin
            if (rd_data)
              rx_second <= rx_hold;
            else
              rx_second <= rx_hold;
            rx_second_full <= 1'b1;
          end else if (!rx_first_full || rd_data) begin
            rx_first      <= rx_hold;
            rx_first_full <= 1'b1;
          end
        end
      end
    end
  end

  // Status flags; a set in the same cycle beats a clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xfer_flag              <= 1'b0;
      collision_flag         <= 1'b0;
      receive_complete_flag  <= 1'b0;
      transfer_complete_flag <= 1'b0;
      select_trigger_flag    <= 1'b0;
      receive_overflow_flag  <= 1'b0;
      clear_armed_xfer       <= 1'b0;
      clear_armed_col        <= 1'b0;
    end else begin
      // arm on status read, clear on data access
      if (reg_read && reg_addr == `OFS_INTERRUPT_STATUS) begin
        clear_armed_xfer <= xfer_flag;
        clear_armed_col  <= collision_flag;
      end else if (rd_data || wr_data) begin
        clear_armed_xfer <= 1'b0;
        clear_armed_col  <= 1'b0;
      end
      // byte end or fallback sets transfer-done
      if (!buffered_mode && (done || fallback))
        xfer_flag <= 1'b1;
      else if (vector_taken ||
               (clear_armed_xfer && (rd_data || wr_data)))
        xfer_flag <= 1'b0;
      // data write during a byte collides
      if (!buffered_mode && wr_data && busy)
        collision_flag <= 1'b1;
      else if (clear_armed_col && (rd_data || wr_data))
        collision_flag <= 1'b0;
      // set on push, drops when buffer drains or written one
      if (buffered_mode && done_d1)
        receive_complete_flag <= 1'b1;
      else if (!buffered_mode || (rd_data && !rx_first_full) ||
               (reg_write && reg_addr == `OFS_INTERRUPT_STATUS &&
                reg_wdata[`F_RX_DONE]))
        receive_complete_flag <= 1'b0;
      // nothing left in shifter or buffer
      if (buffered_mode && done_d2 && !txbuf_full && !pending && !busy)
        transfer_complete_flag <= 1'b1;
      else if (!buffered_mode ||
               (reg_write && reg_addr == `OFS_INTERRUPT_STATUS &&
                reg_wdata[`F_TX_DONE]))
        transfer_complete_flag <= 1'b0;
      // forced fallback noted in buffered mode
      if (buffered_mode && fallback)
        select_trigger_flag <= 1'b1;
      else if (!buffered_mode ||
               (reg_write && reg_addr == `OFS_INTERRUPT_STATUS &&
                reg_wdata[`F_SELECT]))
        select_trigger_flag <= 1'b0;
      // third byte while both stages hold data
      if (buffered_mode && done_d1 && rx_first_full && rx_second_full &&
          !rd_data)
        receive_overflow_flag <= 1'b1;
      else if (!buffered_mode || rd_data)
        receive_overflow_flag <= 1'b0;
    end
  end

  // Read data and interrupt output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
    end else begin
      // any flag but overflow and collision with its enable
      if (buffered_mode)
        irq <= |({receive_complete_flag, transfer_complete_flag,
                  buffer_empty_flag, select_trigger_flag} &
                 interrupt_enables[7:4]);
      else
        irq <= xfer_flag && interrupt_enables[0];
      if (reg_read) begin
        case (reg_addr)
          `OFS_CONTROL_A:         reg_rdata <= control_a;
          `OFS_CONTROL_B:         reg_rdata <= control_b;
          // buffered enables read zero in plain mode
          `OFS_INTERRUPT_ENABLES: reg_rdata <= buffered_mode ?
                                    interrupt_enables :
                                    (interrupt_enables & 8'h01);
          `OFS_INTERRUPT_STATUS:  reg_rdata <= buffered_mode ?
              {receive_complete_flag, transfer_complete_flag,
               buffer_empty_flag, select_trigger_flag, 3'h0,
               receive_overflow_flag} :
              {xfer_flag, collision_flag, 6'h00};
          `OFS_TX_RX_BYTE:        reg_rdata <= buffered_mode ?
                                    rx_second : rx_hold;
          default:                reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule : spi_block

/* shared/spi_map.svh */
// Register offsets, field positions, reset values and divider counts
`ifndef SPI_MAP_SVH
`define SPI_MAP_SVH
`define OFS_CONTROL_A         3'h0
`define OFS_CONTROL_B         3'h1
`define OFS_INTERRUPT_ENABLES 3'h2
`define OFS_INTERRUPT_STATUS  3'h3
`define OFS_TX_RX_BYTE        3'h4
`define RST_REG               8'h00
`define A_BIT_ORDER           6
`define A_MASTER              5
`define A_CLOCK_DOUBLE        4
`define A_DIV_HI              2
`define A_DIV_LO              1
`define A_ENABLE              0
`define B_BUFFERED            7
`define B_WAIT_RECEIVE        6
`define B_SELECT_IGNORE       2
`define B_MODE_HI             1
`define B_MODE_LO             0
`define F_RX_DONE             7
`define F_TX_DONE             6
`define F_EMPTY               5
`define F_SELECT              4
`define F_OVERFLOW            0
`define DIV_CODE4             8'd4
`define DIV_CODE16            8'd16
`define DIV_CODE64            8'd64
`define DIV_CODE128           8'd128
`define EDGES_PER_BYTE        5'd16
`endif

/* shared/spi_pkg.sv */
// Types shared by the serial peripheral block
package spi_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} engine_state_t;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } pins_in_t;
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } pins_out_t;
endpackage : spi_pkg

/* verification/spi_block_properties.sv */
// Port-level properties of the serial peripheral block
`timescale 1ns/10ps
module spi_block_checker
  import spi_pkg::*;
(
  input wire logic       core_clk,     // Clock
  input wire logic       rst,          // Reset
  input wire logic [2:0] reg_addr,     // Offset
  input wire logic [7:0] reg_wdata,    // Write data
  input wire logic       reg_write,    // Write strobe
  input wire logic       reg_read,     // Read strobe
  input wire logic [7:0] reg_rdata,    // Read data
  input wire logic       vector_taken, // Vector taken
  input wire logic       irq,          // Request
  input wire pins_in_t   pins_in,      // Pin inputs
  input wire pins_out_t  pins_out      // Pin outputs
);
  logic [7:0] ca;
  logic [7:0] cb;
  logic [7:0] ie;
  logic [7:0] gap;
  int         half;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Shadow of written settings; hardware may drop the master bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ca <= 8'h00;
      cb <= 8'h00;
      ie <= 8'h00;
    end else if (reg_write) begin
      if (reg_addr == 3'h0) ca <= reg_wdata;
      if (reg_addr == 3'h1) cb <= reg_wdata;
      if (reg_addr == 3'h2) ie <= reg_wdata;
    end
  end

  // Cycles since the serial clock last moved
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) gap <= 8'h00;
    else if ($changed(pins_out.sck)) gap <= 8'h00;
    else if (gap != 8'hff) gap <= gap + 8'h01;
  end

  always_comb begin
    case (ca[2:1])
      2'h0: half = 2;
      2'h1: half = 8;
      2'h2: half = 32;
      default: half = 64;
    endcase
    if (ca[4]) half = half / 2;
  end

  read_idle_a: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("Read data outside read slot");
  unmapped_zero_a: assert property (
    reg_read && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
    else $error("Unmapped offset read nonzero");
  ctrl_unused_a: assert property (
    reg_read && reg_addr == 3'h0 |=> !reg_rdata[7] && !reg_rdata[3])
    else $error("Unused control bits read nonzero");
  flags_unused_a: assert property (
    reg_read && reg_addr == 3'h3 |=> reg_rdata[3:1] == 3'h0)
    else $error("Unused flag bits read nonzero");
  nobuf_enables_a: assert property (
    reg_read && reg_addr == 3'h2 && !cb[7] |=> reg_rdata[7:1] == 7'h00)
    else $error("Buffered enables visible unbuffered");
  nobuf_flags_a: assert property (
    reg_read && reg_addr == 3'h3 && !cb[7]
    |=> reg_rdata[5:4] == 2'h0 && !reg_rdata[0])
    else $error("Buffered flags visible unbuffered");
  disabled_quiet_a: assert property (
    !ca[0] && !$past(ca[0]) && !$past(ca[0], 2)
    |-> !pins_out.sck_oe && !pins_out.mosi_oe && !pins_out.miso_oe)
    else $error("Pins driven while disabled");
  irq_gate_a: assert property (
    ie == 8'h00 && $past(ie) == 8'h00 |-> !irq)
    else $error("Request with all enables off");
  vector_clear_a: assert property (
    vector_taken && !cb[7] && ie == 8'h01 |=> ##1 !irq)
    else $error("Request stands after vector");
  sck_spacing_a: assert property (
    $changed(pins_out.sck) && $past(pins_out.sck_oe) && pins_out.sck_oe
    |-> gap >= half - 1)
    else $error("Serial clock edges too close");

  cover property ($rose(pins_out.sck_oe));
  cover property (vector_taken ##2 !irq);
  cover property (reg_read && reg_addr == 3'h3 ##1 reg_rdata[0]);
endmodule : spi_block_checker

/* verification/spi_far_slave.sv */
// Behavioural remote slave on the serial link
`timescale 1ns/10ps
module spi_far_slave (
  input  wire logic       sck,   // Serial clock
  input  wire logic       mosi,  // Data from master
  input  wire logic       sel_n, // Select, active low
  input  wire logic [1:0] mode,  // Clock mode code
  input  wire logic       lsb,   // Low bit first
  input  wire logic [7:0] tx,    // Byte returned
  output logic            miso,  // Data to master
  output logic      [7:0] rx,    // Last whole byte
  output int              got    // Bytes taken
);
  logic [7:0] sh;
  int         n;
  int         k;

  function automatic logic pick(input int i);
    pick = lsb ? tx[i % 8] : tx[7 - i % 8];
  endfunction : pick

  initial begin
    miso = 1'b0;
    rx = 8'h00;
    got = 0;
    n = 0;
    k = 0;
  end

  // first bit early when sampling leads
  always @(negedge sel_n) begin
    miso = pick(0);
    k = mode[0] ? 0 : 1;
    n = 0;
  end

  // Released line shows no stale value
  always @(posedge sel_n) miso = ~miso;

  always @(sck) begin
    if (!sel_n && (sck ^ mode[1] ^ mode[0])) begin
      sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      n = n + 1;
      if (n == 8) begin
        rx = sh;
        got = got + 1;
        n = 0;
      end
    end else if (!sel_n) begin
      miso = pick(k);
      k = k + 1;
    end
  end
endmodule : spi_far_slave

/* verification/testbench.sv */
// Self-checking bench for the serial peripheral block
`timescale 1ns/10ps
module testbench;
  import spi_pkg::*;
  logic        core_clk;
  logic        rst;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_rdata;
  logic        vector_taken;
  logic        irq;
  logic        ss_n;
  pins_in_t    pins_in;
  pins_out_t   pins_out;
  logic        sl_sel_n;
  logic [1:0]  sl_mode;
  logic        sl_lsb;
  logic [7:0]  sl_tx;
  logic        sl_miso;
  logic [7:0]  sl_rx;
  int          sl_got;
  int          fails;
  int          checked;
  int          n0;
  logic        rd_d;
  logic [15:0] ent;
  logic [7:0]  tx;
  logic [15:0] expq[$];
  string       nameq[$];

  assign pins_in = {1'b0, 1'b0, sl_miso, ss_n};

  spi_block u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .vector_taken(vector_taken), .irq(irq),
    .pins_in(pins_in), .pins_out(pins_out));
  spi_far_slave u_far (.sck(pins_out.sck), .mosi(pins_out.mosi),
    .sel_n(sl_sel_n), .mode(sl_mode), .lsb(sl_lsb), .tx(sl_tx),
    .miso(sl_miso), .rx(sl_rx), .got(sl_got));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    expq.push_back({m, e});
    nameq.push_back($sformatf("register %0d", a));
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
  endtask : rd

  // Bounded wait; a hang ends the run
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 4000 && irq !== lvl; i++) @(posedge core_clk);
    chk("irq level", {7'h00, irq}, {7'h00, lvl});
    if (irq !== lvl) stop_test();
  endtask : wait_irq

  // Read data stands one cycle after the strobe
  always @(posedge core_clk) begin
    rd_d <= reg_read;
    if (rd_d && expq.size() > 0) begin
      ent = expq.pop_front();
      chk(nameq.pop_front(), reg_rdata & ent[15:8], ent[7:0] & ent[15:8]);
    end
  end

  initial begin
    logic [1:0] mm;
    {reg_addr, reg_wdata, reg_write, reg_read, vector_taken} = '0;
    {ss_n, sl_sel_n, sl_mode, sl_lsb, sl_tx, rst} = 14'h3001;
    fails = 0;
    checked = 0;
    void'($urandom(66417));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00, a == 4 ? 8'h00 : 8'hff);
    wr(3'h1, 8'hff);
    wr(3'h2, 8'hff);
    wr(3'h0, 8'hfe);
    wr(3'h6, 8'hff);
    rd(3'h0, 8'h76, 8'hff);
    rd(3'h1, 8'hc7, 8'hff);
    rd(3'h2, 8'hf1, 8'hff);
    rd(3'h6, 8'h00, 8'hff);
    wr(3'h1, 8'h47);
    rd(3'h2, 8'h01, 8'hff);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      mm = m[1:0];
      tx = 8'($urandom);
      sl_tx = 8'($urandom);
      sl_mode = mm;
      sl_lsb = mm[1];
      wr(3'h0, 8'h00);
      wr(3'h1, {6'h00, mm});
      wr(3'h2, 8'h01);
      wr(3'h0, {1'b0, mm[1], 1'b1, mm[0], 1'b0, mm, 1'b1});
      sl_sel_n = 1'b0;
      wr(3'h4, tx);
      if (mm == 2'h0) wr(3'h4, ~tx);
      wait_irq(1'b1);
      if (mm == 2'h2) begin
        @(posedge core_clk);
        vector_taken <= 1'b1;
        @(posedge core_clk);
        vector_taken <= 1'b0;
        wait_irq(1'b0);
      end
      rd(3'h3, mm == 2'h2 ? 8'h00 : {1'b1, mm == 2'h0, 6'h00}, 8'hff);
      rd(3'h4, sl_tx, 8'hff);
      sl_sel_n = 1'b1;
      chk("far byte", sl_rx, tx);
      rd(3'h3, 8'h00, 8'hc0);
      repeat (3) @(posedge core_clk);
      chk("irq cleared", {7'h00, irq}, 8'h00);
    end
    $display("test master modes done");
    for (int m = 0; m < 3; m++) begin
      wr(3'h0, 8'h00);
      wr(3'h2, 8'h00);
      wr(3'h1, m == 0 ? 8'h00 : (m == 1 ? 8'h80 : 8'h84));
      wr(3'h0, 8'h21);
      @(posedge core_clk);
      ss_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(3'h0, m == 2 ? 8'h21 : 8'h01, 8'hff);
      rd(3'h3, m == 0 ? 8'h80 : {3'h0, m == 1, 4'h0}, m == 0 ? 8'h80 : 8'h10);
      @(posedge core_clk);
      ss_n <= 1'b1;
      if (m == 1) wr(3'h3, 8'h10);
      rd(3'h3, 8'h00, 8'h10);
      rd(3'h0, m == 2 ? 8'h21 : 8'h01, 8'hff);
      rd(3'h4, 8'h00, 8'h00);
    end
    $display("test select fallback done");
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hc0);
    wr(3'h2, 8'h40);
    {sl_mode, sl_lsb} = 3'h0;
    sl_tx = 8'($urandom);
    tx = 8'($urandom);
    n0 = sl_got;
    wr(3'h0, 8'h23);
    sl_sel_n = 1'b0;
    wr(3'h4, tx);
    wr(3'h4, ~tx);
    wait_irq(1'b1);
    chk("far count", 8'(sl_got - n0), 8'h02);
    chk("far byte", sl_rx, ~tx);
    rd(3'h3, 8'he0, 8'hf1);
    wr(3'h3, 8'h40);
    wait_irq(1'b0);
    wr(3'h4, tx);
    wait_irq(1'b1);
    rd(3'h3, 8'h01, 8'h01);
    rd(3'h4, sl_tx, 8'hff);
    rd(3'h4, sl_tx, 8'hff);
    rd(3'h3, 8'h00, 8'h81);
    $display("test buffered direct done");
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h80);
    wr(3'h3, 8'h40);
    wr(3'h0, 8'h23);
    n0 = sl_got;
    wr(3'h4, tx);
    rd(3'h3, 8'h00, 8'h20);
    wait_irq(1'b1);
    chk("far count", 8'(sl_got - n0), 8'h02);
    chk("far byte", sl_rx, tx);
    sl_sel_n = 1'b1;
    $display("test buffered dummy done");
    repeat (4) @(posedge core_clk);
    stop_test();
  end
endmodule : testbench

bind spi_block spi_block_checker u_chk (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata),
  .vector_taken(vector_taken), .irq(irq), .pins_in(pins_in),
  .pins_out(pins_out));
